// *** design/dwc_top.sv ***
`timescale 1ns/10ps
module dwc_top
    import dwc_pkg::*;
(
    input  wire logic          MCLK,
    input  wire logic          RSTN,
    input  wire logic          TCK,
    input  wire logic          TRSTN,
    input  wire logic          TAP_SEL,
    input  wire logic          TAP_CAPTURE,
    input  wire logic          TAP_SHIFT,
    input  wire logic          TAP_UPDATE,
    input  wire logic          TAP_IDLE,
    input  wire logic          TDI,
    output logic               TDO,
    input  wire logic          DEBUG_REQUEST,
    input  wire logic          CORE_ACK,
    input  wire dwc_core_bus_t CORE_BUS,
    input  wire logic [1:0]    EXT_COND,
    input  wire logic          MEMORY_REQUEST_LOW,
    input  wire logic          INSTRUCTION_SET_STATE_FLAG,
    output logic               DEBUG_REQUEST_INTERNAL,
    output logic               DEBUG_ACKNOWLEDGE,
    output logic               CORE_INTERRUPT_ENABLE,
    output logic               BREAK_POINT_OUT
);
    // ****************************************************************
    // test clock side: scan chain, debug registers, shadow copies
    // ****************************************************************
    logic [SRW-1:0]    sr_q, sr_d;
    logic [CTRL_W-1:0] ctl_q, ctl_d;
    logic [STAT_W-1:0] st_q, st_d;
    logic [AW-1:0]     rda_q, rda_d;
    logic [DW-1:0]     shd_q [NWR];
    logic [DW-1:0]     shd_d [NWR];
    logic [DW-1:0]     wd_q, wd_d;
    logic [3:0]        wi_q, wi_d;
    logic              tog_q, tog_d;
    logic              rqh_q, rqh_d;
    logic [3:0]        ts1_q, ts2_q;
    logic [AW-1:0]     sa;
    logic              upd, wr, wphit;
    logic [3:0]        six;
    logic [DW-1:0]     rdv;
    logic [STAT_W-1:0] live;

    assign TDO = sr_q[0];
    assign upd = TAP_SEL & TAP_UPDATE;
    assign sa  = sr_q[SR_RW_BIT-1:SR_A_LSB];
    assign wr  = sr_q[SR_RW_BIT];
    assign wphit = (sa[4:3] == WP0_SEL || sa[4:3] == WP1_SEL)
                   && ({1'b0, sa[2:0]} < 4'(NREG));
    assign six = 4'(sa[4] ? NREG : 0) + {1'b0, sa[2:0]};

    // next state of the scan side; the update strobe commits register writes, status reloads live on every clock but a status write
    always_comb begin
        sr_d  = sr_q;
        ctl_d = ctl_q;
        rda_d = rda_q;
        shd_d = shd_q;
        wd_d  = wd_q;
        wi_d  = wi_q;
        tog_d = tog_q;
        // ts order: flag, memory request, request, acknowledge
        live  = {ts2_q[3], ts2_q[2], ~ts2_q[0] & ~ctl_q[CB_INTERRUPT_DISABLE_BIT],
                 ts2_q[1], ts2_q[0]};
        st_d  = live;
        rdv   = '0;
        if (rda_q == A_CTRL) begin
            rdv = DW'(ctl_q);
        end else if (rda_q == A_STAT) begin
            rdv = DW'(st_q);
        end else if ((rda_q[4:3] == WP0_SEL || rda_q[4:3] == WP1_SEL)
                     && ({1'b0, rda_q[2:0]} < 4'(NREG))) begin
            rdv = shd_q[4'(rda_q[4] ? NREG : 0) + {1'b0, rda_q[2:0]}];
        end
        // request latch only opens in run-test/idle so many cores go together
        rqh_d = TAP_IDLE ? ctl_q[CB_RQ] : rqh_q;
        if (TAP_SEL && TAP_CAPTURE) begin
            sr_d[DW-1:0] = rdv;
        end else if (TAP_SEL && TAP_SHIFT) begin
            sr_d = {TDI, sr_q[SRW-1:1]};
        end else if (upd) begin
            rda_d = sa;
            if (wr && sa == A_CTRL) begin
                ctl_d = sr_q[CTRL_W-1:0];
            end
            if (wr && sa == A_STAT) begin
                st_d = sr_q[STAT_W-1:0];
            end
            if (wr && wphit) begin
                shd_d[six] = sr_q[DW-1:0];
                wd_d  = sr_q[DW-1:0];
                wi_d  = six;
                tog_d = ~tog_q;
            end
        end
    end

    // test clock registers, cleared by test reset
    always_ff @(posedge TCK or negedge TRSTN) begin
        if (!TRSTN) begin
            sr_q  <= '0;
            ctl_q <= CTRL_RST;
            st_q  <= STAT_RST;
            rda_q <= '0;
            shd_q <= '{default: '0};
            wd_q  <= '0;
            wi_q  <= '0;
            tog_q <= 1'b0;
            rqh_q <= 1'b0;
            ts1_q <= '0;
            ts2_q <= '0;
        end else begin
            sr_q  <= sr_d;
            ctl_q <= ctl_d;
            st_q  <= st_d;
            rda_q <= rda_d;
            shd_q <= shd_d;
            wd_q  <= wd_d;
            wi_q  <= wi_d;
            tog_q <= tog_d;
            rqh_q <= rqh_d;
            // status inputs may run on any clock, two stages first
            ts1_q <= {INSTRUCTION_SET_STATE_FLAG, MEMORY_REQUEST_LOW,
                      DEBUG_REQUEST_INTERNAL, DEBUG_ACKNOWLEDGE};
            ts2_q <= ts1_q;
        end
    end

    // ****************************************************************
    // core clock side: request and acknowledge, watchpoint compare
    // ****************************************************************
    logic [DW-1:0] wr_q [NWR];
    logic [DW-1:0] wr_d [NWR];
    logic [2:0]    tg_q;
    logic [2:0]    cs1_q, cs2_q;
    logic [2:0]    ps1_q, ps2_q;
    logic          trs1_q, trs2_q;
    logic [1:0]    lk_q, lk_d;
    logic          rqi_q, rqi_d, ack_q, ack_d;
    logic          core_interrupt_enable_q, core_interrupt_enable_d, bp_q, bp_d;
    logic          tedge;
    logic [1:0]    am_hit, dm_hit, rng, en, cv_wr;

    // a word crosses only after the toggle settles; the test side holds it
    // stable for a whole scan, far longer than the three core cycles needed
    assign tedge = tg_q[1] ^ tg_q[2];

    // two watchpoints; watchpoint 1 chain and range inputs are tied low
    for (genvar i = 0; i < 2; i++) begin : g_wp
        logic [C_TOP:0] cb;
        logic [DW-1:0]  av, am, dv, dm, cv, cm;
        assign av = wr_q[i*NREG+AV];
        assign am = wr_q[i*NREG+AM];
        assign dv = wr_q[i*NREG+DV];
        assign dm = wr_q[i*NREG+DM];
        assign cv = wr_q[i*NREG+CV];
        assign cm = wr_q[i*NREG+CM];
        // range, chain, extern, then core control bits
        if (i == 0) begin : g_cpl
            assign cb = {rng[1], lk_q[1], ps2_q[1],
                         CORE_BUS[C_ADDR_HI:0]};
        end else begin : g_end
            assign cb = {1'b0, 1'b0, ps2_q[2], CORE_BUS[C_ADDR_HI:0]};
        end
        // mask is xnor style: a set mask bit always matches
        assign am_hit[i] = &(({av, cv[C_ADDR_HI:0]} ~^ {CORE_BUS.addr, cb[C_ADDR_HI:0]})
                             | {am, cm[C_ADDR_HI:0]});
        assign dm_hit[i] = &(({dv, cv[C_TOP:C_DATA_LO]} ~^ {CORE_BUS.data, cb[C_TOP:C_DATA_LO]})
                             | {dm, cm[C_TOP:C_DATA_LO]});
        assign rng[i]    = am_hit[i] & dm_hit[i];
        assign en[i]     = cv[C_EN];
        assign cv_wr[i]  = tedge && (wi_q == 4'(i*NREG+CV));
    end

    // next state of the core side
    always_comb begin
        wr_d = wr_q;
        if (tedge) begin
            wr_d[wi_q] = wd_q;
        end
        for (int i = 0; i < 2; i++) begin
            // clear wins over capture; latch holds while address misses
            if (cv_wr[i] || !trs2_q) begin
                lk_d[i] = 1'b0;
            end else if (am_hit[i]) begin
                lk_d[i] = dm_hit[i];
            end else begin
                lk_d[i] = lk_q[i];
            end
        end
        rqi_d  = cs2_q[CB_RQ] | ps2_q[0];
        ack_d  = CORE_ACK | cs2_q[CB_ACK];
        core_interrupt_enable_d = ~(CORE_ACK | cs2_q[CB_ACK]) & ~cs2_q[CB_INTERRUPT_DISABLE_BIT];
        bp_d   = |(en & am_hit & dm_hit);
    end

    // core clock registers
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            wr_q   <= '{default: '0};
            tg_q   <= '0;
            cs1_q  <= '0;
            cs2_q  <= '0;
            ps1_q  <= '0;
            ps2_q  <= '0;
            trs1_q <= 1'b0;
            trs2_q <= 1'b0;
            lk_q   <= '0;
            rqi_q  <= 1'b0;
            ack_q  <= 1'b0;
            core_interrupt_enable_q <= 1'b0;
            bp_q   <= 1'b0;
        end else begin
            wr_q   <= wr_d;
            tg_q   <= {tg_q[1:0], tog_q};
            // cross in control bit order so the field constants index them
            cs1_q  <= {ctl_q[CB_INTERRUPT_DISABLE_BIT], rqh_q, ctl_q[CB_ACK]};
            cs2_q  <= cs1_q;
            ps1_q  <= {EXT_COND, DEBUG_REQUEST};
            ps2_q  <= ps1_q;
            trs1_q <= TRSTN;
            trs2_q <= trs1_q;
            lk_q   <= lk_d;
            rqi_q  <= rqi_d;
            ack_q  <= ack_d;
            core_interrupt_enable_q <= core_interrupt_enable_d;
            bp_q   <= bp_d;
        end
    end

    assign DEBUG_REQUEST_INTERNAL = rqi_q;
    assign DEBUG_ACKNOWLEDGE      = ack_q;
    assign CORE_INTERRUPT_ENABLE  = core_interrupt_enable_q;
    assign BREAK_POINT_OUT        = bp_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_req_or: assert property (@(posedge MCLK) disable iff (!RSTN)
        rqi_q == $past(cs2_q[CB_RQ] | ps2_q[0]))
        else $error("internal request is not the OR of its sources");
    a_ack_or: assert property (@(posedge MCLK) disable iff (!RSTN)
        ##1 ack_q == ($past(CORE_ACK) | $past(cs2_q[CB_ACK])))
        else $error("acknowledge is not the OR of core and bit 0");
    a_core_interrupt_enable_gate: assert property (@(posedge MCLK) disable iff (!RSTN)
        core_interrupt_enable_q |-> !$past(ack_d) && !$past(cs2_q[CB_INTERRUPT_DISABLE_BIT]))
        else $error("interrupt enable high while blocked");
    a_brk_enable: assert property (@(posedge MCLK) disable iff (!RSTN)
        !$past(en[0]) && !$past(en[1]) |-> !bp_q)
        else $error("breakpoint raised with both enables clear");
    a_link_clear: assert property (@(posedge MCLK) disable iff (!RSTN)
        $past(cv_wr[1]) |-> !lk_q[1])
        else $error("link latch not cleared by control write");
    a_ctrl_write: assert property (@(posedge TCK) disable iff (!TRSTN)
        upd && !TAP_CAPTURE && !TAP_SHIFT && wr && sa == A_CTRL
        |=> ctl_q == $past(sr_q[CTRL_W-1:0]))
        else $error("control register write lost");
    a_idle_hold: assert property (@(posedge TCK) disable iff (!TRSTN)
        !TAP_IDLE |=> rqh_q == $past(rqh_q))
        else $error("request latch moved outside run-test/idle");
    a_stat_read: assert property (@(posedge TCK) disable iff (!TRSTN)
        TAP_SEL && TAP_CAPTURE && rda_q == A_STAT
        |=> sr_q[ST_CORE_INTERRUPT_ENABLE] == $past(st_q[ST_CORE_INTERRUPT_ENABLE]))
        else $error("status capture does not return interrupt state");
    // interrupt disable alone must hold interrupts off
    a_interrupt_disable_bit_low: assert property (@(posedge MCLK) disable iff (!RSTN)
        $past(cs2_q[CB_INTERRUPT_DISABLE_BIT]) |-> !core_interrupt_enable_q)
        else $error("interrupt enable high with disable bit set");
    a_link_load: assert property (@(posedge MCLK) disable iff (!RSTN)
        $past(am_hit[1]) && !$past(cv_wr[1]) && $past(trs2_q) |-> lk_q[1] == $past(dm_hit[1]))
        else $error("link latch did not take the data match");
    a_link_trst: assert property (@(posedge MCLK) disable iff (!RSTN)
        !trs2_q |=> lk_q == '0)
        else $error("link latches not cleared by test reset");
endmodule : dwc_top

// *** shared/dwc_pkg.sv ***
package dwc_pkg;
    // ****************************************************************
    // widths and scan chain layout
    // ****************************************************************
    localparam int DW        = 32;
    localparam int AW        = 5;
    localparam int SRW       = 38;
    localparam int SR_A_LSB  = 32;
    localparam int SR_RW_BIT = 37;
    localparam int CTRL_W    = 3;
    localparam int STAT_W    = 5;
    localparam int NREG      = 6;
    localparam int NWR       = 2 * NREG;

    // ****************************************************************
    // register addresses in the scan chain address field
    // ****************************************************************
    localparam logic [4:0] A_CTRL  = 5'h00;
    localparam logic [4:0] A_STAT  = 5'h01;
    localparam logic [1:0] WP0_SEL = 2'h1;
    localparam logic [1:0] WP1_SEL = 2'h2;

    // register index inside one watchpoint
    localparam int AV = 0;
    localparam int AM = 1;
    localparam int DV = 2;
    localparam int DM = 3;
    localparam int CV = 4;
    localparam int CM = 5;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int CB_ACK    = 0;
    localparam int CB_RQ     = 1;
    localparam int CB_INTERRUPT_DISABLE_BIT = 2;
    localparam int ST_CORE_INTERRUPT_ENABLE   = 2;
    localparam int C_ADDR_HI = 4;
    localparam int C_DATA_LO = 5;
    localparam int C_TOP     = 7;
    localparam int C_EN      = 8;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam logic [STAT_W-1:0] STAT_RST = 5'h0;

    // core bus; low five bits line up with control bus bits 4:0
    typedef struct packed {
        logic [DW-1:0] addr;
        logic [DW-1:0] data;
        logic          translate_low;
        logic          opcode_fetch_low;
        logic [1:0]    access_size;
        logic          write_not_read;
    } dwc_core_bus_t;
endpackage : dwc_pkg

// *** verification/dwc_scan_host.sv ***
`timescale 1ns/10ps
// ****************************************************************
// scan host model: one 38-bit data register scan per request
// ****************************************************************
module dwc_scan_host
    import dwc_pkg::*;
(
    input  wire logic           tck,
    input  wire logic           trst_n,
    input  wire logic           go,
    input  wire logic           idle_en,
    input  wire logic [SRW-1:0] frame,
    input  wire logic           tdo,
    output logic                sel,
    output logic                cap,
    output logic                shift,
    output logic                upd,
    output logic                idle,
    output logic                tdi,
    output logic                busy,
    output logic [SRW-1:0]      rx
);
    int cnt;

    // idle only between scans; the bench can hold the tap out of idle
    assign idle = idle_en & ~busy;

    // capture, shifts lsb first, update; tdi toggles when it carries nothing
    always @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            {sel, cap, shift, upd, busy, tdi} <= '0;
            cnt <= 0;
            rx  <= '0;
        end else if (!busy) begin
            busy <= go;
            sel  <= go;
            cap  <= go;
            tdi  <= ~tdi;
            cnt  <= 0;
        end else if (cnt <= SRW) begin
            if (cnt > 0)
                rx[cnt-1] <= tdo; // tdo still holds the bit before this shift
            cap   <= 1'b0;
            shift <= (cnt < SRW);
            upd   <= (cnt == SRW);
            tdi   <= (cnt < SRW) ? frame[cnt % SRW] : ~tdi;
            cnt   <= cnt + 1;
        end else begin
            {sel, upd, busy} <= '0;
        end
    end
endmodule : dwc_scan_host

// *** verification/dwc_top_tb.sv ***
`timescale 1ns/10ps
// ****************************************************************
// bench for the debug watchpoint control block
// ****************************************************************
module dwc_top_tb;
    import dwc_pkg::*;
    logic           mclk = 1'b0, rstn = 1'b0, tck = 1'b0, trst_n = 1'b0;
    logic           go = 1'b0, idle_en = 1'b1, dreq = 1'b0, cack = 1'b0;
    logic           mrl = 1'b0, flag = 1'b0;
    logic [1:0]     ext = 2'h0;
    logic [SRW-1:0] frame = '0, rx;
    dwc_core_bus_t  cbus = '0;
    logic           sel, cap, shift, upd, idle, tdi, busy, tdo, rqi, dack, core_interrupt_enable, brk;
    int             n_mismatch = 0, comparisons = 0;
    logic [6:0]     rows [8] = '{7'h01, 7'h42, 7'h0A, 7'h15, 7'h20, 7'h6A, 7'h3E, 7'h5E};

    // free core clock; test clock offset so the two never line up
    always #2.5 mclk = ~mclk;
    initial begin
        #3.3;
        forever #15 tck = ~tck;
    end

    dwc_top dut_u (.MCLK(mclk), .RSTN(rstn), .TCK(tck), .TRSTN(trst_n), .TAP_SEL(sel),
        .TAP_CAPTURE(cap), .TAP_SHIFT(shift), .TAP_UPDATE(upd), .TAP_IDLE(idle), .TDI(tdi),
        .TDO(tdo), .DEBUG_REQUEST(dreq), .CORE_ACK(cack), .CORE_BUS(cbus), .EXT_COND(ext),
        .MEMORY_REQUEST_LOW(mrl), .INSTRUCTION_SET_STATE_FLAG(flag),
        .DEBUG_REQUEST_INTERNAL(rqi), .DEBUG_ACKNOWLEDGE(dack),
        .CORE_INTERRUPT_ENABLE(core_interrupt_enable), .BREAK_POINT_OUT(brk));

    dwc_scan_host host_u (.tck(tck), .trst_n(trst_n), .go(go), .idle_en(idle_en), .frame(frame),
        .tdo(tdo), .sel(sel), .cap(cap), .shift(shift), .upd(upd), .idle(idle), .tdi(tdi),
        .busy(busy), .rx(rx));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // a scan lasts 40 test clock edges; 45 leaves margin
    task automatic scan(input logic rw, input logic [4:0] a, input logic [31:0] d);
        @(posedge tck) frame <= {rw, a, d};
        go <= 1'b1;
        @(posedge tck) go <= 1'b0;
        repeat (45) @(posedge tck);
    endtask : scan

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        scan(1'b1, a, d);
    endtask : wr

    // the second scan captures what the first one addressed
    task automatic rd(input logic [4:0] a, output logic [31:0] v);
        scan(1'b0, a, '0);
        scan(1'b0, a, '0);
        v = rx[31:0];
    endtask : rd

    task automatic wp(input logic [1:0] s, input int idx, input logic [31:0] d);
        wr({s, 3'(idx)}, d);
    endtask : wp

    task automatic bus(input logic [31:0] a, input logic [31:0] d, input logic e);
        @(posedge mclk) cbus.addr <= a;
        cbus.data <= d;
        repeat (3) @(posedge mclk);
        #1;
        chk(32'(brk), 32'(e));
    endtask : bus

    task automatic stop_test;
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    // watchdog: the whole sequence needs well under this
    initial begin
        #300000;
        n_mismatch++;
        stop_test();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [31:0] v;
        repeat (2) @(posedge mclk) rstn <= 1'b0;
        rstn <= 1'b1;
        repeat (2) @(posedge tck);
        trst_n <= 1'b1;
        repeat (4) @(posedge tck);
        rd(A_CTRL, v);
        chk(v, 32'h0);
        chk({29'h0, rqi, dack, core_interrupt_enable}, 32'h1);
        $display("test reset done");
        // rows: core ack, control bits, then request, acknowledge, enable
        foreach (rows[i]) begin
            @(posedge mclk) cack <= rows[i][6];
            wr(A_CTRL, 32'(rows[i][5:3]));
            rd(A_CTRL, v);
            chk(v, 32'(rows[i][5:3]));
            repeat (4) @(posedge tck);
            chk(32'({rqi, dack, core_interrupt_enable}), 32'(rows[i][2:0]));
        end
        $display("test control table done");
        // request latch must hold while the tap stays out of idle
        @(posedge mclk) cack <= 1'b0;
        // the last table row left the request set; drop it while idle is open
        wr(A_CTRL, 32'h0);
        @(posedge tck) idle_en <= 1'b0;
        wr(A_CTRL, 32'h2);
        repeat (8) @(posedge tck);
        chk(32'(rqi), 32'h0);
        @(posedge tck) idle_en <= 1'b1;
        repeat (4) @(posedge tck);
        chk(32'(rqi), 32'h1);
        wr(A_CTRL, 32'h0);
        @(posedge mclk) dreq <= 1'b1;
        repeat (6) @(posedge mclk);
        #1;
        chk(32'(rqi), 32'h1);
        @(posedge mclk) dreq <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        chk(32'(rqi), 32'h0);
        $display("test request latch done");
        @(posedge mclk) {cack, mrl, flag} <= 3'h7;
        repeat (4) @(posedge tck);
        rd(A_STAT, v);
        chk(v, 32'h19);
        @(posedge mclk) {cack, mrl, flag} <= 3'h0;
        wr(A_STAT, 32'h1F);
        rd(A_STAT, v);
        chk(v, 32'h04);
        $display("test status done");
        // range pair: first 256 bytes but not the first 32
        wp(WP1_SEL, AM, 32'h1F);
        wp(WP1_SEL, DM, '1);
        wp(WP1_SEL, CM, 32'hFF);
        wp(WP0_SEL, AM, 32'hFF);
        wp(WP0_SEL, DM, '1);
        wp(WP0_SEL, CM, 32'h7F);
        wp(WP0_SEL, CV, 32'h100);
        bus(32'h10, 0, 1'b0);
        bus(32'h40, 0, 1'b1);
        bus(32'h100, 0, 1'b0);
        $display("test range done");
        // chain: wp1 is a qualifier with enable off
        wp(WP1_SEL, DV, 32'h5);
        wp(WP1_SEL, DM, 32'hFFFFFFF0);
        // the range pair left the link set; a control write clears it
        wp(WP1_SEL, CV, 32'h0);
        wp(WP0_SEL, CM, 32'hBF);
        wp(WP0_SEL, CV, 32'h140);
        bus(32'h40, 0, 1'b0);
        bus(32'h10, 32'h3, 1'b0);
        bus(32'h40, 0, 1'b0);
        bus(32'h10, 32'h5, 1'b1);
        bus(32'h40, 0, 1'b1);
        wp(WP1_SEL, CV, 32'h0);
        bus(32'h40, 0, 1'b0);
        // extern input: watchpoint 0 waits for condition 0
        wp(WP0_SEL, CM, 32'hDF);
        wp(WP0_SEL, CV, 32'h160);
        bus(32'h40, 0, 1'b0);
        @(posedge mclk) ext <= 2'h1;
        bus(32'h40, 0, 1'b1);
        $display("test chain done");
        // data watchpoint: word write at one address, any data
        wp(WP0_SEL, AV, 32'h80);
        wp(WP0_SEL, AM, 32'h0);
        wp(WP0_SEL, CM, 32'hF0);
        wp(WP0_SEL, CV, 32'h10D);
        @(posedge mclk) {cbus.opcode_fetch_low, cbus.access_size, cbus.write_not_read} <= 4'hD;
        bus(32'h80, 0, 1'b1);
        bus(32'h84, 0, 1'b0);
        @(posedge mclk) cbus.write_not_read <= 1'b0;
        bus(32'h80, 0, 1'b0);
        $display("test data watchpoint done");
        // software breakpoint: pattern planted in place of a saved fetch word
        wp(WP0_SEL, AM, '1);
        wp(WP0_SEL, DV, 32'hA5A55A5A);
        wp(WP0_SEL, DM, 32'h0);
        wp(WP0_SEL, CM, 32'hF7);
        wp(WP0_SEL, CV, 32'h100);
        rd({WP0_SEL, 3'(DV)}, v);
        chk(v, 32'hA5A55A5A);
        @(posedge mclk) cbus.opcode_fetch_low <= 1'b0;
        bus(32'h200, 32'h12345678, 1'b0);
        bus(32'h200, 32'hA5A55A5A, 1'b1);
        bus(32'h200, 32'h12345678, 1'b0);
        $display("test software breakpoint done");
        stop_test();
    end
endmodule : dwc_top_tb
